// File: hw/btsc_brake_timing_stop_control.sv
// Contract
// - Alarm while moving stops motor, applies brake.
// - Speed threshold 0..10000 mm/s, default 10, immediate.
// - Wait time 10..100 x 10 ms, default 50.
// - Brake applied when speed below threshold.
// - Brake applied when wait time exceeded.
// - First of speed or timeout applies brake.
// - Zero-speed alarm stop: decelerate, then stopped timing.
// - Stop select 0/1/2, active after restart.
// - Main power loss without disable: dynamic brake.
// - Alarm stop defaults to zero-speed stopping.
// - Stopped: brake at disable, power off delayed.
// - Brake stays released during overtravel.
`timescale 1ns/1ps

module btsc_brake_timing_stop_control
	import btsc_pkg::*;
#(
	parameter int          TICK_CYCLES = btsc_pkg::UNIT_CYCLES,
	parameter logic [15:0] STANDSTILL  = btsc_pkg::STANDSTILL_RST
)
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire btsc_pkg::btsc_wb_req_s wbReq,
	output      btsc_pkg::btsc_wb_rsp_s wbRsp,
	input  wire logic                  alarmIn,
	input  wire logic                  overtravelIn,
	input  wire logic                  mainPowerOkIn,
	input  wire logic signed [15:0]    motorSpeed,
	output      btsc_pkg::btsc_drive_s drive
);
	import btsc_pkg::*;

	localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
	localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

	typedef struct packed {
		btsc_state_e       st;
		logic [1:0]        alarmSync;
		logic [1:0]        otSync;
		logic [1:0]        mainOkSync;
		logic              svEnable;
		logic              zeroSpeedAlarm;
		logic [THR_W-1:0]  spdThr;
		logic [WAIT_W-1:0] waitTime;
		logic [DLY_W-1:0]  stopDelay;
		logic [1:0]        stopSelReg;
		logic [1:0]        stopSelAct;
		logic [PRE_W-1:0]  preCnt;
		logic [WAIT_W-1:0] tickCnt;
		logic              mainLossStop;
		logic              alarmStop;
		btsc_drive_s       drv;
		btsc_wb_rsp_s      rsp;
	} btsc_regs_s;

	// Settings return to their defaults on reset; all other state clears
	localparam btsc_regs_s S_RST = '{
		st:             ST_OFF,
		alarmSync:      '0,
		otSync:         '0,
		mainOkSync:     '0,
		svEnable:       1'b0,
		zeroSpeedAlarm: 1'b1,
		spdThr:         THR_RST,
		waitTime:       WAIT_RST,
		stopDelay:      DLY_RST,
		stopSelReg:     STOP_SEL_RST,
		stopSelAct:     STOP_SEL_RST,
		preCnt:         '0,
		tickCnt:        '0,
		mainLossStop:   1'b0,
		alarmStop:      1'b0,
		drv:            '0,
		rsp:            '0
	};

	btsc_regs_s        s_q;
	btsc_regs_s        s_d;

	logic              alarm;
	logic              overtravel;
	logic              mainOk;
	logic [SPD_W-1:0]  speedMag;
	logic              belowThr;
	logic              standstill;
	logic              busHit;
	logic              busWrite;
	logic              tick;
	logic              waitOver;
	logic              delayOver;
	logic              dbAfterStop;
	logic [31:0]       wdat;
	logic [31:0]       statusWord;

	assign alarm      = s_q.alarmSync[1];
	assign overtravel = s_q.otSync[1];
	assign mainOk     = s_q.mainOkSync[1];

	// Direction does not matter for the brake decision
	assign speedMag   = motorSpeed[SPD_W-1] ? SPD_W'(-motorSpeed) : SPD_W'(motorSpeed);
	assign belowThr   = speedMag < {{(SPD_W-THR_W){1'b0}}, s_q.spdThr};
	assign standstill = speedMag < STANDSTILL;

	assign busHit     = wbReq.cyc & wbReq.stb & ~s_q.rsp.ack;
	assign busWrite   = busHit & wbReq.we;
	assign wdat       = wbReq.dat;

	assign tick       = (s_q.preCnt == PRE_LAST);
	// Elapsed whole units equal to or beyond the setting count as exceeded
	assign waitOver   = s_q.tickCnt >= s_q.waitTime;
	assign delayOver  = s_q.tickCnt >= {1'b0, s_q.stopDelay};

	// Mode after stopping; power loss without disable keeps the dynamic brake
	assign dbAfterStop = (s_q.stopSelAct == STOP_DB_HOLD_DB) | s_q.mainLossStop;

	assign statusWord = {16'h0000,
		5'h00, s_q.st,
		s_q.stopSelAct, s_q.mainLossStop, s_q.alarmStop,
		mainOk, overtravel, alarm,
		s_q.drv.brakeReleaseOut};

	always_comb
	begin
		s_d = s_q;

		s_d.alarmSync  = {s_q.alarmSync[0], alarmIn};
		s_d.otSync     = {s_q.otSync[0], overtravelIn};
		s_d.mainOkSync = {s_q.mainOkSync[0], mainPowerOkIn};

		// Wishbone slave: one-cycle registered ack, unmapped reads give zero
		s_d.rsp.ack = busHit;
		s_d.rsp.dat = 32'h0000_0000;
		if (busHit && !wbReq.we)
		begin
			case (wbReq.adr)
				REG_CTRL:
					s_d.rsp.dat = {29'h0000_0000, 1'b0, s_q.zeroSpeedAlarm, s_q.svEnable};
				REG_SPD_THR:
					s_d.rsp.dat = {18'h00000, s_q.spdThr};
				REG_WAIT_TIME:
					s_d.rsp.dat = {25'h0000000, s_q.waitTime};
				REG_STOP_DELAY:
					s_d.rsp.dat = {26'h0000000, s_q.stopDelay};
				REG_STOP_SELECT:
					s_d.rsp.dat = {28'h0000000, s_q.stopSelAct, s_q.stopSelReg};
				REG_STATUS:
					s_d.rsp.dat = statusWord;
				default:
					s_d.rsp.dat = 32'h0000_0000;
			endcase
		end

		// Out-of-range settings are ignored, new values act at once except the stop selection
		if (busWrite)
		begin
			case (wbReq.adr)
				REG_CTRL:
					if (wbReq.sel[0])
					begin
						s_d.svEnable       = wdat[CTRL_ENABLE_BIT];
						s_d.zeroSpeedAlarm = wdat[CTRL_ZSPEED_BIT];
						// Selection only switches over on a restart with the servo off
						if (wdat[CTRL_RESTART_BIT] && s_q.st == ST_OFF)
							s_d.stopSelAct = s_q.stopSelReg;
					end
				REG_SPD_THR:
					if (wbReq.sel[1:0] == 2'h3 && wdat[31:THR_W] == 18'h00000 && wdat[THR_W-1:0] <= THR_MAX)
						s_d.spdThr = wdat[THR_W-1:0];
				REG_WAIT_TIME:
					if (wbReq.sel[0] && wdat[31:WAIT_W] == 25'h0000000 &&
						wdat[WAIT_W-1:0] >= WAIT_MIN && wdat[WAIT_W-1:0] <= WAIT_MAX)
						s_d.waitTime = wdat[WAIT_W-1:0];
				REG_STOP_DELAY:
					if (wbReq.sel[0] && wdat[31:DLY_W] == 26'h0000000 && wdat[DLY_W-1:0] <= DLY_MAX)
						s_d.stopDelay = wdat[DLY_W-1:0];
				REG_STOP_SELECT:
					if (wbReq.sel[0] && wdat[31:2] == 30'h00000000 && wdat[1:0] != 2'h3)
						s_d.stopSelReg = wdat[1:0];
				default:
				begin
				end
			endcase
		end

		// 10 ms time base, restarted together with the unit counter
		s_d.preCnt = tick ? '0 : PRE_W'(s_q.preCnt + 1'b1);
		if (tick && s_q.tickCnt != TICK_SAT)
			s_d.tickCnt = WAIT_W'(s_q.tickCnt + 1'b1);

		case (s_q.st)
			ST_OFF:
			begin
				// Mode after stopping stays on the output while the servo is off
				s_d.drv.brakeReleaseOut = 1'b0;
				s_d.drv.motorPower      = 1'b0;
				s_d.drv.decelRequest    = 1'b0;
				if (s_q.svEnable && !alarm && mainOk)
				begin
					s_d.drv.dynamicBrakeStop = 1'b0;
					s_d.st                  = ST_RUN;
					s_d.drv.motorPower      = 1'b1;
					s_d.drv.brakeReleaseOut = 1'b1;
					s_d.mainLossStop        = 1'b0;
					s_d.alarmStop           = 1'b0;
				end
			end
			ST_RUN:
			begin
				// Overtravel is not a stop cause, so the brake stays released
				s_d.drv.brakeReleaseOut = 1'b1;
				s_d.drv.motorPower      = 1'b1;
				s_d.drv.dynamicBrakeStop = 1'b0;
				s_d.drv.decelRequest    = 1'b0;
				s_d.preCnt              = '0;
				s_d.tickCnt             = '0;
				if (alarm)
				begin
					s_d.alarmStop = 1'b1;
					if (standstill)
					begin
						// Power goes at once on an alarm at standstill, whatever the delay
						s_d.st                   = ST_HALT;
						s_d.drv.motorPower       = 1'b0;
						s_d.drv.brakeReleaseOut  = 1'b0;
						s_d.drv.dynamicBrakeStop = dbAfterStop;
					end
					else if (s_q.zeroSpeedAlarm)
					begin
						s_d.st               = ST_ZERO_DECEL;
						s_d.drv.decelRequest = 1'b1;
					end
					else
					begin
						s_d.st                   = ST_STOP_MOVING;
						s_d.drv.motorPower       = 1'b0;
						s_d.drv.dynamicBrakeStop = (s_q.stopSelAct != STOP_COAST);
					end
				end
				else if (!mainOk)
				begin
					s_d.mainLossStop         = 1'b1;
					s_d.st                   = standstill ? ST_HALT : ST_STOP_MOVING;
					s_d.drv.motorPower       = 1'b0;
					s_d.drv.dynamicBrakeStop = 1'b1;
					if (standstill)
						s_d.drv.brakeReleaseOut = 1'b0;
				end
				else if (!s_q.svEnable)
				begin
					if (standstill)
					begin
						s_d.st                  = ST_STOPPED_DELAY;
						s_d.drv.brakeReleaseOut = 1'b0;
					end
					else
					begin
						s_d.st                   = ST_STOP_MOVING;
						s_d.drv.motorPower       = 1'b0;
						s_d.drv.dynamicBrakeStop = (s_q.stopSelAct != STOP_COAST);
					end
				end
			end
			ST_STOP_MOVING:
			begin
				// Whichever comes first: slow enough or waited long enough
				if (belowThr || waitOver)
					s_d.drv.brakeReleaseOut = 1'b0;
				if (standstill && (belowThr || waitOver || !s_q.drv.brakeReleaseOut))
				begin
					s_d.st                   = ST_HALT;
					s_d.drv.brakeReleaseOut  = 1'b0;
					s_d.drv.dynamicBrakeStop = dbAfterStop;
				end
			end
			ST_ZERO_DECEL:
			begin
				s_d.drv.decelRequest = 1'b1;
				if (!mainOk)
				begin
					// Without main power the deceleration cannot be held
					s_d.mainLossStop         = 1'b1;
					s_d.st                   = ST_STOP_MOVING;
					s_d.drv.decelRequest     = 1'b0;
					s_d.drv.motorPower       = 1'b0;
					s_d.drv.dynamicBrakeStop = 1'b1;
					s_d.preCnt               = '0;
					s_d.tickCnt              = '0;
				end
				else if (standstill)
				begin
					s_d.st                  = ST_STOPPED_DELAY;
					s_d.drv.decelRequest    = 1'b0;
					s_d.drv.brakeReleaseOut = 1'b0;
					s_d.preCnt              = '0;
					s_d.tickCnt             = '0;
				end
			end
			ST_STOPPED_DELAY:
			begin
				// Power is held so the brake can grip before torque is lost
				s_d.drv.brakeReleaseOut = 1'b0;
				if (delayOver || !mainOk)
				begin
					s_d.st                   = ST_HALT;
					s_d.drv.motorPower       = 1'b0;
					s_d.mainLossStop         = s_q.mainLossStop | ~mainOk;
					s_d.drv.dynamicBrakeStop = dbAfterStop | ~mainOk;
				end
			end
			ST_HALT:
			begin
				s_d.drv.brakeReleaseOut  = 1'b0;
				s_d.drv.motorPower       = 1'b0;
				s_d.drv.decelRequest     = 1'b0;
				s_d.drv.dynamicBrakeStop = dbAfterStop;
				// A fresh enable is needed after the stop completes
				if (!s_q.svEnable && !alarm && mainOk)
				begin
					s_d.st                   = ST_OFF;
				end
			end
			default:
			begin
				s_d.st  = ST_OFF;
				s_d.drv = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q <= S_RST;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign wbRsp = s_q.rsp;
	assign drive = s_q.drv;

endmodule // btsc_brake_timing_stop_control

// File: hw/btsc_pkg.sv
package btsc_pkg;

	// Register byte offsets on the Wishbone slave
	localparam logic [4:0]  REG_CTRL        = 5'h00;
	localparam logic [4:0]  REG_SPD_THR     = 5'h04;
	localparam logic [4:0]  REG_WAIT_TIME   = 5'h08;
	localparam logic [4:0]  REG_STOP_DELAY  = 5'h0C;
	localparam logic [4:0]  REG_STOP_SELECT = 5'h10;
	localparam logic [4:0]  REG_STATUS      = 5'h14;
	localparam int          ADR_W           = 5;

	// Control register fields
	localparam int          CTRL_ENABLE_BIT  = 0;
	localparam int          CTRL_ZSPEED_BIT  = 1;
	localparam int          CTRL_RESTART_BIT = 2;

	// Setting widths, ranges and defaults
	localparam int          THR_W           = 14;
	localparam int          WAIT_W          = 7;
	localparam int          DLY_W           = 6;
	localparam int          SPD_W           = 16;
	localparam logic [13:0] THR_MAX         = 14'h2710;
	localparam logic [13:0] THR_RST         = 14'h000A;
	localparam logic [6:0]  WAIT_MIN        = 7'h0A;
	localparam logic [6:0]  WAIT_MAX        = 7'h64;
	localparam logic [6:0]  WAIT_RST        = 7'h32;
	localparam logic [5:0]  DLY_MAX         = 6'h32;
	localparam logic [5:0]  DLY_RST         = 6'h00;
	localparam logic [6:0]  TICK_SAT        = 7'h7F;

	// Stop method field encodings
	localparam logic [1:0]  STOP_DB_HOLD_DB = 2'h0;
	localparam logic [1:0]  STOP_DB_COAST   = 2'h1;
	localparam logic [1:0]  STOP_COAST      = 2'h2;
	localparam logic [1:0]  STOP_SEL_RST    = 2'h0;

	// Settings count in units of 10 ms
	localparam int          UNIT_TIME_MS    = 10;
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          UNIT_CYCLES     = (UNIT_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// Speed magnitude below which the motor counts as stopped
	localparam logic [15:0] STANDSTILL_RST  = 16'h0001;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_RUN,
		ST_STOP_MOVING,
		ST_ZERO_DECEL,
		ST_STOPPED_DELAY,
		ST_HALT
	} btsc_state_e;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		logic [ADR_W-1:0]  adr;
		logic [3:0]        sel;
		logic [31:0]       dat;
	} btsc_wb_req_s;

	typedef struct packed {
		logic              ack;
		logic [31:0]       dat;
	} btsc_wb_rsp_s;

	typedef struct packed {
		logic              brakeReleaseOut;
		logic              motorPower;
		logic              dynamicBrakeStop;
		logic              decelRequest;
	} btsc_drive_s;

endpackage

// File: testbench/brake_timing_stop_control_tb_top.sv
`timescale 1ns/1ps
module brake_timing_stop_control_tb_top;
	import btsc_pkg::*;
	logic               clk = 0;
	logic               nrst;
	btsc_wb_req_s       req;
	btsc_wb_rsp_s       rsp;
	btsc_drive_s        drv;
	logic [3:0]         dv;
	logic               alarm, ot, mainOk;
	logic signed [15:0] tgt, spd;
	logic [31:0]        r;
	logic [1:0]         act = 2'h0;
	int                 n, cyc = 0, n_errors = 0, compares = 0;
	assign dv = drv;
	always #5 clk = ~clk;
	btsc_brake_timing_stop_control #(.TICK_CYCLES(4)) dut (.clk(clk), .nrst(nrst), .wbReq(req), .wbRsp(rsp),
		.alarmIn(alarm), .overtravelIn(ot), .mainPowerOkIn(mainOk), .motorSpeed(spd), .drive(drv));
	btsc_motor_model u_motor (.clk(clk), .nrst(nrst), .drive(drv), .target(tgt), .motorSpeed(spd));
	task tally_and_finish;
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wb(input int we, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= {2'b11, we[0], a, 4'hF, d};
		// Held until ack; only the bench timeout ends a hung wait
		do
			@(posedge clk);
		while (rsp.ack !== 1'b1);
		r = rsp.dat;
		req <= '0;
	endtask
	task automatic waitBit(input int b, input logic v);
		for (n = 0; dv[b] !== v && n < 20000; n++)
			@(posedge clk);
	endtask
	task automatic stillWait;
		for (n = 0; spd !== 16'sh0 && n < 20000; n++)
			@(posedge clk);
		repeat (4) @(posedge clk);
	endtask
	task automatic runUp(input logic signed [15:0] s);
		tgt <= s;
		wb(1, REG_CTRL, 32'h3);
		waitBit(2, 1'b1);
		repeat (3) @(posedge clk);
	endtask
	task automatic runStop(input logic [1:0] sel, input logic signed [15:0] s, input logic [31:0] thr,
		input logic [31:0] wt, input int lo, input int hi);
		wb(1, REG_STOP_SELECT, {30'h0, sel});
		wb(0, REG_STOP_SELECT, 32'h0); chk(r, {28'h0, act, sel});
		wb(1, REG_CTRL, 32'h6);
		wb(0, REG_STOP_SELECT, 32'h0); chk(r, {28'h0, sel, sel});
		act = sel;
		wb(1, REG_SPD_THR, thr);
		wb(1, REG_WAIT_TIME, wt);
		runUp(s);
		wb(1, REG_CTRL, 32'h2);
		waitBit(2, 1'b0);
		chk({31'h0, dv[1]}, {31'h0, sel != 2'h2});
		waitBit(3, 1'b0);
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
		stillWait();
		chk({31'h0, dv[1]}, {31'h0, sel == 2'h0});
		tgt <= 16'sh0;
		$display("stop test %0d done", sel);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_errors++;
			tally_and_finish();
		end
	end
	initial
	begin
		nrst = 0; req = '0; alarm = 0; ot = 0; mainOk = 1; tgt = 16'sh0;
		repeat (10) @(posedge clk);
		nrst <= 1;
		wb(0, REG_SPD_THR, 32'h0); chk(r, 32'hA);
		wb(0, REG_WAIT_TIME, 32'h0); chk(r, 32'h32);
		wb(0, REG_CTRL, 32'h0); chk(r, 32'h2);
		wb(0, 5'h18, 32'h0); chk(r, 32'h0);
		wb(1, REG_SPD_THR, 32'h2711); wb(0, REG_SPD_THR, 32'h0); chk(r, 32'hA);
		wb(1, REG_SPD_THR, 32'h2710); wb(0, REG_SPD_THR, 32'h0); chk(r, 32'h2710);
		wb(1, REG_WAIT_TIME, 32'h9); wb(1, REG_WAIT_TIME, 32'h65);
		wb(0, REG_WAIT_TIME, 32'h0); chk(r, 32'h32);
		wb(1, REG_STOP_SELECT, 32'h3); wb(0, REG_STOP_SELECT, 32'h0); chk(r, 32'h0);
		$display("register test done");
		runStop(2'h0, -16'sh3E8, 32'h384, 32'h64, 20, 35);
		runStop(2'h1, 16'shFA0, 32'h0, 32'hA, 38, 43);
		runStop(2'h2, 16'sh12C, 32'hFA, 32'h64, 45, 60);
		runUp(16'sh200);
		alarm <= 1;
		waitBit(0, 1'b1); chk({31'h0, n < 5}, 32'h1);
		waitBit(3, 1'b0); chk({31'h0, n < 30}, 32'h1);
		alarm <= 0;
		wb(1, REG_CTRL, 32'h2);
		stillWait();
		wb(0, REG_STATUS, 32'h0); chk(r, 32'h98);
		$display("alarm test done");
		runUp(16'sh200);
		ot <= 1;
		repeat (8) @(posedge clk);
		chk({31'h0, dv[3]}, 32'h1);
		ot <= 0;
		mainOk <= 0;
		waitBit(2, 1'b0);
		chk({31'h0, dv[1]}, 32'h1);
		mainOk <= 1;
		wb(1, REG_CTRL, 32'h2);
		stillWait();
		chk({31'h0, dv[1]}, 32'h1);
		wb(0, REG_STATUS, 32'h0); chk(r, 32'hA8);
		$display("power loss test done");
		wb(1, REG_STOP_DELAY, 32'h2);
		wb(1, REG_STOP_DELAY, 32'h33); wb(0, REG_STOP_DELAY, 32'h0); chk(r, 32'h2);
		runUp(16'sh0);
		wb(1, REG_CTRL, 32'h2);
		waitBit(3, 1'b0);
		chk({31'h0, dv[2]}, 32'h1);
		waitBit(2, 1'b0);
		chk({31'h0, n >= 6 && n <= 10}, 32'h1);
		$display("stopped test done");
		tally_and_finish();
	end
endmodule // brake_timing_stop_control_tb_top

// File: testbench/btsc_brake_timing_stop_control_assertions.sv
`timescale 1ns/1ps
module btsc_brake_timing_stop_control_assertions
	import btsc_pkg::*;
#(
	parameter int TICK_CYCLES = 4
)
(
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire btsc_pkg::btsc_wb_req_s wbReq,
	input wire btsc_pkg::btsc_wb_rsp_s wbRsp,
	input wire logic                   alarmIn,
	input wire logic                   overtravelIn,
	input wire logic                   mainPowerOkIn,
	input wire logic signed [15:0]     motorSpeed,
	input wire btsc_pkg::btsc_drive_s  drive
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	int unsigned waitQ;
	// Counts unpowered cycles with the brake still open
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			waitQ <= 0;
		else
			waitQ <= (!drive.motorPower && drive.brakeReleaseOut) ? waitQ + 1 : 0;
	property p_ackNext;
		wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack;
	endproperty
	property p_ackPulse;
		wbRsp.ack |=> !wbRsp.ack;
	endproperty
	property p_datIdle;
		!wbRsp.ack |-> wbRsp.dat == 32'h0;
	endproperty
	property p_alarmStop;
		alarmIn [*4] |-> !drive.motorPower || drive.decelRequest || !drive.brakeReleaseOut;
	endproperty
	property p_waitBound;
		waitQ <= 100 * TICK_CYCLES + 2;
	endproperty
	property p_mainLoss;
		drive.motorPower && !drive.decelRequest && !alarmIn && !mainPowerOkIn ##1 !mainPowerOkIn [*2]
			|=> !drive.motorPower && drive.dynamicBrakeStop;
	endproperty
	property p_decelPower;
		drive.decelRequest |-> drive.motorPower;
	endproperty
	property p_zeroStop;
		drive.decelRequest && motorSpeed == 16'sh0 |-> ##[1:2] !drive.brakeReleaseOut;
	endproperty
	a_ackNext: assert property (p_ackNext) else $error("no ack after request");
	a_ackPulse: assert property (p_ackPulse) else $error("ack longer than one cycle");
	a_datIdle: assert property (p_datIdle) else $error("read data without ack");
	a_alarmStop: assert property (p_alarmStop) else $error("alarm left motor running");
	a_waitBound: assert property (p_waitBound) else $error("brake wait overrun");
	a_mainLoss: assert property (p_mainLoss) else $error("main loss without dynamic brake");
	a_decelPower: assert property (p_decelPower) else $error("decel with power off");
	a_zeroStop: assert property (p_zeroStop) else $error("no brake after zero speed");
	c_read: cover property (wbRsp.ack && !wbReq.we);
	c_brake: cover property ($fell(drive.brakeReleaseOut) && !drive.motorPower);
	c_decel: cover property (drive.decelRequest);
endmodule // btsc_brake_timing_stop_control_assertions

bind btsc_brake_timing_stop_control btsc_brake_timing_stop_control_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clk(clk), .nrst(nrst), .wbReq(wbReq), .wbRsp(wbRsp), .alarmIn(alarmIn), .overtravelIn(overtravelIn),
	.mainPowerOkIn(mainPowerOkIn), .motorSpeed(motorSpeed), .drive(drive));

// File: testbench/btsc_motor_model.sv
`timescale 1ns/1ps
module btsc_motor_model
	import btsc_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire btsc_pkg::btsc_drive_s drive,
	input  wire logic signed [15:0]    target,
	output      logic signed [15:0]    motorSpeed
);
	logic signed [15:0] step;
	// Friction alone is slow; dynamic braking and deceleration stop it faster
	always_comb
		step = drive.decelRequest ? 16'sh40 : (drive.dynamicBrakeStop ? 16'sh4 : 16'sh1);
	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
			motorSpeed <= '0;
		else if (drive.motorPower && !drive.decelRequest)
			motorSpeed <= target;
		else if (motorSpeed > step)
			motorSpeed <= motorSpeed - step;
		else if (motorSpeed < -step)
			motorSpeed <= motorSpeed + step;
		else
			motorSpeed <= '0;
endmodule // btsc_motor_model
